// *** qic_pkg.sv ***
// Purpose: Shared constants and types for the ingress QoS classifier
// Assumes: 100 MHz clock, classic Wishbone register access
// Notes:   Queue index 0 is the best-effort queue
package qic_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NPORTS     = 24;
	localparam int PORT_W     = 5;
	localparam int QUEUE_W    = 2;
	localparam int PRIO_W     = 3;
	localparam int PRIO_N     = 8;
	localparam int DSCP_W     = 6;
	localparam int DSCP_N     = 64;
	localparam int LEN_W      = 16;
	localparam int RATE_W     = 20;
	localparam int CRED_W     = 22;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W     = PORT_W + QUEUE_W + LEN_W;
	localparam int LEVEL_W    = 5;
	localparam int WB_ADR_W   = 12;
	localparam int WB_DAT_W   = 32;
	localparam int WB_SEL_W   = 4;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [WB_ADR_W-1:0] ADR_CTRL      = 12'h000;
	localparam logic [WB_ADR_W-1:0] ADR_DROPS     = 12'h004;
	localparam logic [WB_ADR_W-1:0] ADR_RL_EN     = 12'h008;
	localparam logic [WB_ADR_W-1:0] ADR_PRIO_MAP  = 12'h00C;
	localparam logic [WB_ADR_W-1:0] ADR_LEVEL     = 12'h010;
	localparam logic [3:0]          REGION_DSCP   = 4'h1;
	localparam logic [3:0]          REGION_RATE   = 4'h2;
	localparam int                  CTRL_TRUST    = 0;
	localparam int                  CTRL_RESTORE  = 1;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [15:0]        PRIO_MAP_RST  = 16'hFA50;
	localparam logic [RATE_W-1:0]  RATE_RST      = 20'h19000;
	localparam logic [RATE_W-1:0]  RATE_MIN      = 20'h00DAC;
	localparam logic [RATE_W-1:0]  RATE_MAX      = 20'hF4240;
	localparam logic [QUEUE_W-1:0] QUEUE_BEST    = 2'h0;
	localparam int                 REFILL_SHIFT  = 3;
	localparam int                 BURST_SHIFT   = 4;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 1000000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

	typedef enum logic {
		QIC_TRUST_PRIO = 1'b0,
		QIC_TRUST_DSCP = 1'b1
	} qic_trust_t;

endpackage

// *** qic_fifo.sv ***
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   in_ready_o falls when full, out_valid_o when empty
`timescale 1ns/1ps
module qic_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     in_valid_i,
	output logic                          in_ready_o,
	input  wire logic [WIDTH-1:0]         in_data_i,
	output logic                          out_valid_o,
	input  wire logic                     out_ready_i,
	output logic [WIDTH-1:0]              out_data_o,
	output logic [$clog2(DEPTH):0]        level_o
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W:0]   count_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_q != DEPTH[PTR_W:0]);
	assign out_valid_o = (count_q != '0);
	assign out_data_o  = mem_q[rd_ptr_q];
	assign level_o     = count_q;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// ****************************************************************
	// Storage
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	// ****************************************************************
	// Pointers and fill count
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule

// *** qic_top.sv ***
// Purpose: Ingress QoS classifier with per-port rate limiting
// Assumes: Packet descriptors arrive from logic on clk_i
// Notes:   Dropped packets are consumed and counted, never queued
`timescale 1ns/1ps
module qic_top #(
	parameter int TICK_CYCLES = qic_pkg::TICK_CYCLES
) (
	input  wire logic                            clk_i,
	input  wire logic                            rst_i,
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [qic_pkg::WB_ADR_W-1:0]    wb_adr_i,
	input  wire logic [qic_pkg::WB_SEL_W-1:0]    wb_sel_i,
	input  wire logic [qic_pkg::WB_DAT_W-1:0]    wb_dat_i,
	output logic [qic_pkg::WB_DAT_W-1:0]         wb_dat_o,
	output logic                                 wb_ack_o,
	input  wire logic                            pkt_valid_i,
	output logic                                 pkt_ready_o,
	input  wire logic [qic_pkg::PORT_W-1:0]      pkt_port_i,
	input  wire logic                            pkt_has_prio_i,
	input  wire logic [qic_pkg::PRIO_W-1:0]      pkt_prio_i,
	input  wire logic                            pkt_has_dscp_i,
	input  wire logic [qic_pkg::DSCP_W-1:0]      pkt_dscp_i,
	input  wire logic [qic_pkg::LEN_W-1:0]       pkt_len_i,
	output logic                                 out_valid_o,
	input  wire logic                            out_ready_i,
	output logic [qic_pkg::PORT_W-1:0]           out_port_o,
	output logic [qic_pkg::QUEUE_W-1:0]          out_queue_o,
	output logic [qic_pkg::LEN_W-1:0]            out_len_o
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [qic_pkg::WB_DAT_W-1:0] qic_merge(
		input logic [qic_pkg::WB_DAT_W-1:0] old_v,
		input logic [qic_pkg::WB_DAT_W-1:0] new_v,
		input logic [qic_pkg::WB_SEL_W-1:0] sel
	);
		logic [qic_pkg::WB_DAT_W-1:0] r;
		r = old_v;
		for (int b = 0; b < qic_pkg::WB_SEL_W; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [qic_pkg::RATE_W-1:0] qic_clamp_rate(
		input logic [qic_pkg::WB_DAT_W-1:0] v
	);
		logic [qic_pkg::RATE_W-1:0] r;
		if (v < {12'h000, qic_pkg::RATE_MIN}) begin
			r = qic_pkg::RATE_MIN;
		end else if (v > {12'h000, qic_pkg::RATE_MAX}) begin
			r = qic_pkg::RATE_MAX;
		end else begin
			r = v[qic_pkg::RATE_W-1:0];
		end
		return r;
	endfunction

	function automatic logic qic_in_dscp(input logic [qic_pkg::WB_ADR_W-1:0] a);
		return a[11:8] == qic_pkg::REGION_DSCP;
	endfunction

	function automatic logic qic_in_rate(input logic [qic_pkg::WB_ADR_W-1:0] a);
		return (a[11:8] == qic_pkg::REGION_RATE) && (a[7:2] < 6'(qic_pkg::NPORTS));
	endfunction

	function automatic logic [qic_pkg::QUEUE_W-1:0] qic_dscp_default(input int idx);
		logic [qic_pkg::DSCP_W-1:0] c;
		c = idx[qic_pkg::DSCP_W-1:0];
		return c[qic_pkg::DSCP_W-1 -: qic_pkg::QUEUE_W];
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int TICK_CNT_W = $clog2(TICK_CYCLES + 1);

	qic_pkg::qic_trust_t              trust_q;
	logic [qic_pkg::QUEUE_W-1:0]      dscp_map_q [qic_pkg::DSCP_N];
	logic [2*qic_pkg::PRIO_N-1:0]     prio_map_q;
	logic [qic_pkg::NPORTS-1:0]       rl_en_q;
	logic [qic_pkg::RATE_W-1:0]       rate_q [qic_pkg::NPORTS];
	logic [qic_pkg::CRED_W-1:0]       credit_q [qic_pkg::NPORTS];
	logic [qic_pkg::CRED_W-1:0]       credit_d [qic_pkg::NPORTS];
	logic [qic_pkg::WB_DAT_W-1:0]     drops_q;
	logic [TICK_CNT_W-1:0]            tick_cnt_q;
	logic                             tick;
	logic                             ack_q;
	logic [qic_pkg::WB_DAT_W-1:0]     rdat_q;
	logic [qic_pkg::WB_DAT_W-1:0]     rdat;
	logic                             req;
	logic                             wr;
	logic [qic_pkg::DSCP_W-1:0]       wr_idx;
	logic [qic_pkg::WB_DAT_W-1:0]     ctrl_rd;
	logic [qic_pkg::WB_DAT_W-1:0]     ctrl_wr;
	logic [qic_pkg::QUEUE_W-1:0]      queue;
	logic                             port_ok;
	logic                             conform;
	logic                             limited;
	logic                             accept;
	logic                             push;
	logic                             fifo_ready;
	logic [qic_pkg::LEVEL_W-1:0]      level;
	logic [qic_pkg::FIFO_W-1:0]       fifo_out;

	// ****************************************************************
	// Wishbone slave, one wait state, unmapped reads return zero
	// ****************************************************************
	assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr       = req & wb_we_i;
	assign wr_idx   = wb_adr_i[7:2];
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign ctrl_rd  = {31'h00000000, trust_q};
	assign ctrl_wr  = qic_merge(ctrl_rd, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	always_comb begin
		rdat = '0;
		if (qic_in_dscp(wb_adr_i)) begin
			rdat = {30'h00000000, dscp_map_q[wr_idx]};
		end else if (qic_in_rate(wb_adr_i)) begin
			rdat = {12'h000, rate_q[wr_idx[qic_pkg::PORT_W-1:0]]};
		end else begin
			unique case (wb_adr_i)
				qic_pkg::ADR_CTRL:     rdat = ctrl_rd;
				qic_pkg::ADR_DROPS:    rdat = drops_q;
				qic_pkg::ADR_RL_EN:    rdat = {8'h00, rl_en_q};
				qic_pkg::ADR_PRIO_MAP: rdat = {16'h0000, prio_map_q};
				qic_pkg::ADR_LEVEL:    rdat = {27'h0000000, level};
				default:               rdat = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= '0;
		end else if (req) begin
			rdat_q <= rdat;
		end
	end

	// ****************************************************************
	// Trust mode and priority-tag map
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trust_q <= qic_pkg::QIC_TRUST_PRIO;
		end else if (wr && wb_adr_i == qic_pkg::ADR_CTRL) begin
			trust_q <= qic_pkg::qic_trust_t'(ctrl_wr[qic_pkg::CTRL_TRUST]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prio_map_q <= qic_pkg::PRIO_MAP_RST;
		end else if (wr && wb_adr_i == qic_pkg::ADR_PRIO_MAP) begin
			prio_map_q <= (2*qic_pkg::PRIO_N)'(qic_merge({16'h0000, prio_map_q}, wb_dat_i, wb_sel_i));
		end
	end

	// ****************************************************************
	// Code-point table
	// ****************************************************************
	generate
		for (genvar i = 0; i < qic_pkg::DSCP_N; i++) begin : g_dscp
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					dscp_map_q[i] <= qic_dscp_default(i);
				end else if (wr && wb_adr_i == qic_pkg::ADR_CTRL && ctrl_wr[qic_pkg::CTRL_RESTORE]) begin
					dscp_map_q[i] <= qic_dscp_default(i);
				end else if (wr && qic_in_dscp(wb_adr_i) && wr_idx == qic_pkg::DSCP_W'(i) && wb_sel_i[0]) begin
					dscp_map_q[i] <= wb_dat_i[qic_pkg::QUEUE_W-1:0];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Rate limiter settings
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rl_en_q <= '0;
		end else if (wr && wb_adr_i == qic_pkg::ADR_RL_EN) begin
			rl_en_q <= qic_pkg::NPORTS'(qic_merge({8'h00, rl_en_q}, wb_dat_i, wb_sel_i));
		end
	end

	generate
		for (genvar p = 0; p < qic_pkg::NPORTS; p++) begin : g_rate
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					rate_q[p] <= qic_pkg::RATE_RST;
				end else if (wr && qic_in_rate(wb_adr_i) && wr_idx == qic_pkg::DSCP_W'(p)) begin
					rate_q[p] <= qic_clamp_rate(qic_merge({12'h000, rate_q[p]}, wb_dat_i, wb_sel_i));
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Refill tick, one per millisecond
	// ****************************************************************
	assign tick = (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// ****************************************************************
	// Token buckets in bytes
	// ****************************************************************
	always_comb begin
		for (int p = 0; p < qic_pkg::NPORTS; p++) begin
			logic [qic_pkg::CRED_W-1:0] refill;
			logic [qic_pkg::CRED_W-1:0] cap;
			logic [qic_pkg::CRED_W:0]   sum;
			logic [qic_pkg::CRED_W-1:0] c;
			refill = qic_pkg::CRED_W'(rate_q[p] >> qic_pkg::REFILL_SHIFT);
			cap    = refill << qic_pkg::BURST_SHIFT;
			sum    = {1'b0, credit_q[p]} + {1'b0, refill};
			c      = credit_q[p];
			if (!rl_en_q[p]) begin
				c = cap;
			end else if (tick) begin
				c = (sum > {1'b0, cap}) ? cap : sum[qic_pkg::CRED_W-1:0];
			end
			if (push && rl_en_q[p] && pkt_port_i == p[qic_pkg::PORT_W-1:0]) begin
				if (c >= qic_pkg::CRED_W'(pkt_len_i)) begin
					c = c - qic_pkg::CRED_W'(pkt_len_i);
				end else begin
					c = '0;
				end
			end
			credit_d[p] = c;
		end
	end

	always_ff @(posedge clk_i) begin
		for (int p = 0; p < qic_pkg::NPORTS; p++) begin
			if (rst_i) begin
				credit_q[p] <= '0;
			end else begin
				credit_q[p] <= credit_d[p];
			end
		end
	end

	// ****************************************************************
	// Classification
	// ****************************************************************
	always_comb begin
		queue = qic_pkg::QUEUE_BEST;
		unique case (trust_q)
			qic_pkg::QIC_TRUST_PRIO: begin
				if (pkt_has_prio_i) begin
					queue = prio_map_q[{pkt_prio_i, 1'b0} +: qic_pkg::QUEUE_W];
				end
			end
			qic_pkg::QIC_TRUST_DSCP: begin
				if (pkt_has_dscp_i) begin
					queue = dscp_map_q[pkt_dscp_i];
				end
			end
		endcase
	end

	// ****************************************************************
	// Admission: over-rate packets are consumed but not queued
	// ****************************************************************
	assign port_ok     = (pkt_port_i < qic_pkg::PORT_W'(qic_pkg::NPORTS));
	assign conform     = port_ok && (credit_q[port_ok ? pkt_port_i : '0] >= qic_pkg::CRED_W'(pkt_len_i));
	assign limited     = port_ok && rl_en_q[pkt_port_i] && !conform;
	assign pkt_ready_o = fifo_ready;
	assign accept      = pkt_valid_i & fifo_ready;
	assign push        = accept & ~limited;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drops_q <= '0;
		end else if (accept && limited) begin
			drops_q <= drops_q + 1'b1;
		end
	end

	// ****************************************************************
	// Output queue
	// ****************************************************************
	qic_fifo #(
		.WIDTH (qic_pkg::FIFO_W),
		.DEPTH (qic_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_ready),
		.in_data_i   ({pkt_port_i, queue, pkt_len_i}),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i),
		.out_data_o  (fifo_out),
		.level_o     (level)
	);

	assign out_port_o  = fifo_out[qic_pkg::FIFO_W-1 -: qic_pkg::PORT_W];
	assign out_queue_o = fifo_out[qic_pkg::LEN_W +: qic_pkg::QUEUE_W];
	assign out_len_o   = fifo_out[qic_pkg::LEN_W-1:0];

endmodule

// *** qic_top_properties.sv ***
// Purpose: Port-level properties of the ingress classifier
// Assumes: Byte enables gate register writes
// Notes:   Queue checks hold until the first rate-enable write
`timescale 1ns/1ps
module qic_top_checker #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        pkt_valid_i,
	input wire logic        pkt_ready_o,
	input wire logic [4:0]  pkt_port_i,
	input wire logic        pkt_has_prio_i,
	input wire logic [2:0]  pkt_prio_i,
	input wire logic        pkt_has_dscp_i,
	input wire logic [5:0]  pkt_dscp_i,
	input wire logic        out_valid_o,
	input wire logic [4:0]  out_port_o,
	input wire logic [1:0]  out_queue_o
);
	logic        trust_q;
	logic        lim_q;
	logic [15:0] pmap_q;
	logic [1:0]  tbl_q [64];
	logic        wr;
	logic        rd;
	logic        acc;
	logic        has_f;
	logic [1:0]  q_exp;
	logic [1:0]  tbl_rd;

	// ****
	// Shadow of the mapping registers
	// ****
	assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
	assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
	assign acc = pkt_valid_i && pkt_ready_o && !out_valid_o && !lim_q;
	assign has_f = trust_q ? pkt_has_dscp_i : pkt_has_prio_i;
	assign q_exp = trust_q ? tbl_q[pkt_dscp_i] : pmap_q[{pkt_prio_i, 1'h0} +: 2];
	assign tbl_rd = tbl_q[wb_adr_i[7:2]];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trust_q <= 1'h0;
			lim_q   <= 1'h0;
		end else if (wr && wb_adr_i == qic_pkg::ADR_CTRL && wb_sel_i[0]) begin
			trust_q <= wb_dat_i[0];
		end else if (wr && wb_adr_i == qic_pkg::ADR_RL_EN) begin
			lim_q <= 1'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pmap_q <= qic_pkg::PRIO_MAP_RST;
		end else if (wr && wb_adr_i == qic_pkg::ADR_PRIO_MAP) begin
			for (int b = 0; b < 2; b++) begin
				if (wb_sel_i[b]) begin
					pmap_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 64; i++) begin
			if (rst_i || (wr && wb_adr_i == qic_pkg::ADR_CTRL && wb_sel_i[0] && wb_dat_i[1])) begin
				tbl_q[i] <= i[5:4];
			end else if (wr && wb_sel_i[0] && wb_adr_i == {qic_pkg::REGION_DSCP, i[5:0], 2'h0}) begin
				tbl_q[i] <= wb_dat_i[1:0];
			end
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_queue; acc && has_f |=> out_queue_o == $past(q_exp); endproperty
	a_queue: assert property (p_queue) else $error("wrong queue for trusted field");
	property p_best; acc && !has_f |=> out_queue_o == qic_pkg::QUEUE_BEST; endproperty
	a_best: assert property (p_best) else $error("untagged packet not best effort");
	property p_pass; acc |=> out_valid_o && out_port_o == $past(pkt_port_i); endproperty
	a_pass: assert property (p_pass) else $error("packet lost with limiter off");
	property p_tbl_rd; rd && wb_adr_i[11:8] == qic_pkg::REGION_DSCP |=> wb_dat_o == {30'h0, $past(tbl_rd)}; endproperty
	a_tbl_rd: assert property (p_tbl_rd) else $error("code point entry readback");
	property p_ctrl_rd; rd && wb_adr_i == qic_pkg::ADR_CTRL |=> wb_dat_o == {31'h0, trust_q}; endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback");
	property p_rl_rst; rd && wb_adr_i == qic_pkg::ADR_RL_EN && !lim_q |=> wb_dat_o == 32'h0; endproperty
	a_rl_rst: assert property (p_rl_rst) else $error("limiter enabled after reset");

	c_full: cover property (!pkt_ready_o);
	c_q3: cover property (out_valid_o && out_queue_o == 2'h3);
	c_restore: cover property (wr && wb_adr_i == qic_pkg::ADR_CTRL && wb_dat_i[1]);
endmodule

bind qic_top qic_top_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pkt_valid_i(pkt_valid_i), .pkt_ready_o(pkt_ready_o), .pkt_port_i(pkt_port_i),
	.pkt_has_prio_i(pkt_has_prio_i), .pkt_prio_i(pkt_prio_i), .pkt_has_dscp_i(pkt_has_dscp_i),
	.pkt_dscp_i(pkt_dscp_i), .out_valid_o(out_valid_o), .out_port_o(out_port_o), .out_queue_o(out_queue_o)
);

// *** qic_port_src.sv ***
// Purpose: Switch port model delivering packet descriptors
// Assumes: Descriptor held until ready is seen at a rising edge
// Notes:   Fields invert once released, so stale values never match
`timescale 1ns/1ps
module qic_port_src (
	input  wire logic        clk_i,
	input  wire logic        ready_i,
	output logic             valid_o,
	output logic [4:0]       port_o,
	output logic             has_prio_o,
	output logic [2:0]       prio_o,
	output logic             has_dscp_o,
	output logic [5:0]       dscp_o,
	output logic [15:0]      len_o
);
	initial begin
		valid_o = 1'h0;
		{port_o, has_prio_o, prio_o, has_dscp_o, dscp_o, len_o} = 32'h0;
	end

	task automatic put(input logic [4:0] p, input logic hp, input logic [2:0] pr, input logic hd,
			input logic [5:0] d, input logic [15:0] l, input int gap);
		repeat (gap + 1) @(posedge clk_i);
		valid_o <= 1'h1;
		{port_o, has_prio_o, prio_o, has_dscp_o, dscp_o, len_o} <= {p, hp, pr, hd, d, l};
		// Held until ready is seen high at a rising edge
		do @(posedge clk_i); while (ready_i !== 1'h1);
		valid_o <= 1'h0;
		{port_o, has_prio_o, prio_o, has_dscp_o, dscp_o, len_o} <= ~{p, hp, pr, hd, d, l};
	endtask
endmodule

// *** qic_top_test.sv ***
// Purpose: Self-checking bench for the ingress classifier
// Assumes: Register map and reset values of qic_pkg
// Notes:   Limiter tick shortened to 20 cycles
`timescale 1ns/1ps
module qic_top_test;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        wb_cyc_i = 1'h0;
	logic        wb_stb_i = 1'h0;
	logic        wb_we_i = 1'h0;
	logic [11:0] wb_adr_i = 12'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        out_ready_i = 1'h0;
	logic        pkt_valid_i, pkt_ready_o, pkt_has_prio_i, pkt_has_dscp_i, out_valid_o;
	logic [4:0]  pkt_port_i, out_port_o;
	logic [2:0]  pkt_prio_i;
	logic [5:0]  pkt_dscp_i;
	logic [15:0] pkt_len_i, out_len_o;
	logic [1:0]  out_queue_o;
	logic [31:0] rd_v;
	int          n_checks = 0;
	int          n_mismatch = 0;
	int          cycles = 0;

	qic_top #(.TICK_CYCLES(20)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pkt_valid_i(pkt_valid_i), .pkt_ready_o(pkt_ready_o), .pkt_port_i(pkt_port_i),
		.pkt_has_prio_i(pkt_has_prio_i), .pkt_prio_i(pkt_prio_i), .pkt_has_dscp_i(pkt_has_dscp_i),
		.pkt_dscp_i(pkt_dscp_i), .pkt_len_i(pkt_len_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
		.out_port_o(out_port_o), .out_queue_o(out_queue_o), .out_len_o(out_len_o)
	);
	qic_port_src src_u (
		.clk_i(clk_i), .ready_i(pkt_ready_o), .valid_o(pkt_valid_i), .port_o(pkt_port_i),
		.has_prio_o(pkt_has_prio_i), .prio_o(pkt_prio_i), .has_dscp_o(pkt_has_dscp_i),
		.dscp_o(pkt_dscp_i), .len_o(pkt_len_i)
	);

	always #5 clk_i = ~clk_i;

	// ****
	// Shared tasks
	// ****
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb_io(input logic we, input logic [11:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
		{wb_adr_i, wb_dat_i, wb_sel_i} <= {adr, dat, sel};
		// Request held until ack is sampled high at a rising edge
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		rd_v = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask

	task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
		wb_io(1'h1, adr, dat, 4'hF);
	endtask

	task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
		wb_io(1'h0, adr, 32'h0, 4'hF);
		chk(rd_v, exp);
	endtask

	task automatic take(input logic [4:0] p, input logic [1:0] q, input logic [15:0] l);
		@(negedge clk_i);
		while (out_valid_o !== 1'h1) @(negedge clk_i);
		chk({9'h0, out_port_o, out_queue_o, out_len_o}, {9'h0, p, q, l});
		@(posedge clk_i);
		out_ready_i <= 1'h1;
		@(posedge clk_i);
		out_ready_i <= 1'h0;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rd_chk(qic_pkg::ADR_CTRL, 32'h0);
		rd_chk(qic_pkg::ADR_PRIO_MAP, {16'h0, qic_pkg::PRIO_MAP_RST});
		rd_chk(qic_pkg::ADR_RL_EN, 32'h0);
		rd_chk(12'h200, {12'h0, qic_pkg::RATE_RST});
		rd_chk(12'h1FC, 32'h3);
		rd_chk(12'h7FC, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_tag();
		for (int L = 0; L < 8; L++) src_u.put(5'h1, 1'h1, L[2:0], 1'h0, 6'h0, 16'h40 + 16'(L), L % 2);
		src_u.put(5'h1, 1'h0, 3'h7, 1'h1, 6'h3F, 16'h50, 0);
		rd_chk(qic_pkg::ADR_LEVEL, 32'h9);
		for (int L = 0; L < 8; L++) take(5'h1, qic_pkg::PRIO_MAP_RST[2*L +: 2], 16'h40 + 16'(L));
		take(5'h1, qic_pkg::QUEUE_BEST, 16'h50);
		$display("t_tag done");
	endtask

	task automatic t_dscp();
		wr(qic_pkg::ADR_CTRL, 32'h1);
		wr(12'h10C, 32'h3);
		wb_io(1'h1, 12'h110, 32'h3, 4'hE);
		rd_chk(12'h10C, 32'h3);
		rd_chk(12'h110, 32'h0);
		src_u.put(5'h2, 1'h1, 3'h0, 1'h1, 6'h3, 16'h60, 0);
		src_u.put(5'h2, 1'h1, 3'h7, 1'h1, 6'h4, 16'h61, 1);
		src_u.put(5'h2, 1'h1, 3'h7, 1'h0, 6'h3, 16'h62, 0);
		take(5'h2, 2'h3, 16'h60);
		take(5'h2, 2'h0, 16'h61);
		take(5'h2, qic_pkg::QUEUE_BEST, 16'h62);
		wr(qic_pkg::ADR_CTRL, 32'h3);
		rd_chk(qic_pkg::ADR_CTRL, 32'h1);
		rd_chk(12'h10C, 32'h0);
		src_u.put(5'h2, 1'h0, 3'h0, 1'h1, 6'h3, 16'h63, 0);
		take(5'h2, 2'h0, 16'h63);
		$display("t_dscp done");
	endtask

	task automatic t_fill();
		for (int i = 0; i < 16; i++) src_u.put(5'h5, 1'h0, 3'h0, 1'h1, 6'(4 * i), 16'(i), 0);
		@(negedge clk_i);
		chk({31'h0, pkt_ready_o}, 32'h0);
		rd_chk(qic_pkg::ADR_LEVEL, 32'h10);
		for (int i = 0; i < 16; i++) take(5'h5, 2'(i / 4), 16'(i));
		rd_chk(qic_pkg::ADR_LEVEL, 32'h0);
		$display("t_fill done");
	endtask

	task automatic t_rate();
		wr(12'h208, 32'h100);
		rd_chk(12'h208, {12'h0, qic_pkg::RATE_MIN});
		wr(12'h210, 32'hFFFFF);
		rd_chk(12'h210, {12'h0, qic_pkg::RATE_MAX});
		wr(qic_pkg::ADR_RL_EN, 32'h4);
		src_u.put(5'h2, 1'h0, 3'h0, 1'h0, 6'h0, 16'hFFFF, 0);
		src_u.put(5'h3, 1'h0, 3'h0, 1'h0, 6'h0, 16'hFFFF, 0);
		take(5'h3, 2'h0, 16'hFFFF);
		rd_chk(qic_pkg::ADR_DROPS, 32'h1);
		repeat (45) @(posedge clk_i);
		src_u.put(5'h2, 1'h0, 3'h0, 1'h0, 6'h0, 16'h320, 0);
		take(5'h2, 2'h0, 16'h320);
		src_u.put(5'h2, 1'h0, 3'h0, 1'h0, 6'h0, 16'hFFFF, 0);
		rd_chk(qic_pkg::ADR_DROPS, 32'h2);
		wr(qic_pkg::ADR_RL_EN, 32'h0);
		src_u.put(5'h2, 1'h0, 3'h0, 1'h0, 6'h0, 16'hFFFF, 0);
		take(5'h2, 2'h0, 16'hFFFF);
		$display("t_rate done");
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset();
		t_tag();
		t_dscp();
		t_fill();
		t_rate();
		close_out();
	end
endmodule
